// >>> src/acfg_regs.sv
// configuration and trim register bank of the converter
`timescale 1ns/10ps
`include "acfg_params.svh"

// Overview of operation
// - A fixed 16-bit maker code reads back at two byte addresses, writes ignored.
// - With the hold bit clear, streamed addresses step per the direction bit.
// - With the hold bit set, every streamed byte uses the same address.
// - A zero-to-one change of the reset trigger resets all digital logic except the trigger register and the pulse flop once.
// - Gain code bits 14:8 sit in bits 6:0 of gain-high, reset 100 0000.
// - Gain code bits 7:0 fill gain-low, and the code is high then low.
// - Code 0x0000, 0x4000, 0x7fff map to 500, 725 and 950 mVp-p range.
// - Direction zero decrements with wrap to top, one increments with wrap.
module acfg_regs #(
	parameter logic [15:0] VENDOR_CODE = 16'h0a5c // arbitrary value
) (
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire acfg_pkg::acfg_req_t req,
	input  wire logic              req_valid,
	input  wire logic              address_direction_bit,
	output logic                   rsp_valid,
	output logic [7:0]             rsp_rdata,
	output logic [14:0]            fullscale_gain_code,
	output logic [14:0]            offset_trim_code,
	output logic                   digital_reset_pulse,
	output logic                   hold_address
);
	acfg_pkg::acfg_state_t state_q, state_d;
	logic [14:0] addr_q, addr_d;
	logic [7:0]  user_cfg_q, user_cfg_d;
	logic [7:0]  dig_reset_q, dig_reset_d;
	logic [7:0]  gain_hi_q, gain_hi_d;
	logic [7:0]  gain_lo_q, gain_lo_d;
	logic [7:0]  ofs_hi_q, ofs_hi_d;
	logic [7:0]  ofs_lo_q, ofs_lo_d;
	logic        rsp_valid_d;
	logic [7:0]  rsp_rdata_d;
	logic        dres_pulse_d;
	logic [14:0] cur_addr;
	logic        wr_en;
	logic        soft_rst;

	function automatic logic [14:0] next_addr(input logic [14:0] a,
	                                          input logic hold,
	                                          input logic up);
		if (hold)
			next_addr = a;
		else if (up)
			next_addr = (a == `ACFG_ADDR_MAX) ? 15'h0000 : a + 15'h0001;
		else
			next_addr = (a == 15'h0000) ? `ACFG_ADDR_MAX : a - 15'h0001;
	endfunction

	function automatic logic [7:0] read_byte(input logic [14:0] a,
	                                         input logic [7:0] uc,
	                                         input logic [7:0] dr,
	                                         input logic [7:0] gh,
	                                         input logic [7:0] gl,
	                                         input logic [7:0] oh,
	                                         input logic [7:0] ol);
		case (a)
			`ACFG_OFS_VENDOR_HI: read_byte = VENDOR_CODE[15:8];
			`ACFG_OFS_VENDOR_LO: read_byte = VENDOR_CODE[7:0];
			`ACFG_OFS_USER_CFG:  read_byte = uc;
			`ACFG_OFS_DIG_RESET: read_byte = dr;
			`ACFG_OFS_GAIN_HI:   read_byte = gh;
			`ACFG_OFS_GAIN_LO:   read_byte = gl;
			`ACFG_OFS_OFFSET_HI: read_byte = oh;
			`ACFG_OFS_OFFSET_LO: read_byte = ol;
			default:             read_byte = 8'h00;
		endcase
	endfunction

	// soft reset raised one cycle after the rising edge of the trigger
	assign soft_rst = rst | digital_reset_pulse;
	assign wr_en    = req_valid & req.wr;

	always_comb begin
		cur_addr = (req.start || state_q == acfg_pkg::ACFG_IDLE) ?
		           req.addr : addr_q;
		state_d      = state_q;
		addr_d       = addr_q;
		user_cfg_d   = user_cfg_q;
		dig_reset_d  = dig_reset_q;
		gain_hi_d    = gain_hi_q;
		gain_lo_d    = gain_lo_q;
		ofs_hi_d     = ofs_hi_q;
		ofs_lo_d     = ofs_lo_q;
		rsp_valid_d  = 1'b0;
		rsp_rdata_d  = rsp_rdata;
		dres_pulse_d = 1'b0;
		case (state_q)
			acfg_pkg::ACFG_IDLE,
			acfg_pkg::ACFG_STREAM: begin
				if (req_valid) begin
					state_d = acfg_pkg::ACFG_STREAM;
					addr_d  = next_addr(cur_addr,
					          user_cfg_q[`ACFG_HOLD_ADDR_BIT],
					          address_direction_bit);
					rsp_valid_d = 1'b1;
					rsp_rdata_d = read_byte(cur_addr, user_cfg_q,
					              dig_reset_q, gain_hi_q, gain_lo_q,
					              ofs_hi_q, ofs_lo_q);
				end
			end
			default: state_d = acfg_pkg::ACFG_IDLE;
		endcase
		if (wr_en) begin
			case (cur_addr)
				`ACFG_OFS_USER_CFG:  user_cfg_d = req.wdata;
				`ACFG_OFS_DIG_RESET: begin
					dig_reset_d = req.wdata;
					// edge only; the bit stays as written
					dres_pulse_d = req.wdata[`ACFG_DIG_RESET_BIT] &
					               ~dig_reset_q[`ACFG_DIG_RESET_BIT];
				end
				`ACFG_OFS_GAIN_HI:   gain_hi_d = req.wdata & `ACFG_HI_FIELD_MASK;
				`ACFG_OFS_GAIN_LO:   gain_lo_d = req.wdata;
				`ACFG_OFS_OFFSET_HI: ofs_hi_d  = req.wdata & `ACFG_HI_FIELD_MASK;
				`ACFG_OFS_OFFSET_LO: ofs_lo_d  = req.wdata;
				default: ; // vendor code and holes ignore writes
			endcase
		end
	end

	// the trigger register itself survives its own reset so the bit
	// is not self-clearing; everything else except the digital_reset_pulse flop returns to defaults
	always_ff @(posedge sys_clk) begin
		if (rst)
			dig_reset_q <= `ACFG_RST_DIG_RESET;
		else
			dig_reset_q <= dig_reset_d;
		if (rst)
			digital_reset_pulse <= 1'b0;
		else
			digital_reset_pulse <= dres_pulse_d;
		if (soft_rst) begin
			state_q    <= acfg_pkg::ACFG_IDLE;
			addr_q     <= 15'h0000;
			user_cfg_q <= `ACFG_RST_USER_CFG;
			gain_hi_q  <= `ACFG_RST_GAIN_HI;
			gain_lo_q  <= `ACFG_RST_GAIN_LO;
			ofs_hi_q   <= `ACFG_RST_OFFSET_HI;
			ofs_lo_q   <= `ACFG_RST_OFFSET_LO;
			rsp_valid  <= 1'b0;
			rsp_rdata  <= 8'h00;
			fullscale_gain_code <= `ACFG_GAIN_DEFAULT;
			offset_trim_code    <= `ACFG_GAIN_DEFAULT;
			hold_address        <= 1'b0;
		end else begin
			state_q    <= state_d;
			addr_q     <= addr_d;
			user_cfg_q <= user_cfg_d;
			gain_hi_q  <= gain_hi_d;
			gain_lo_q  <= gain_lo_d;
			ofs_hi_q   <= ofs_hi_d;
			ofs_lo_q   <= ofs_lo_d;
			rsp_valid  <= rsp_valid_d;
			rsp_rdata  <= rsp_rdata_d;
			// analog trim maps the code linearly 500..950 mVp-p
			fullscale_gain_code <= {gain_hi_d[6:0], gain_lo_d};
			offset_trim_code    <= {ofs_hi_d[6:0], ofs_lo_d};
			hold_address        <= user_cfg_d[`ACFG_HOLD_ADDR_BIT];
		end
	end

	// a request in the soft reset cycle gets no answer and only a trigger write is kept, so soft_rst masks it
	a_vendor_read_fixed: assert property (
		@(posedge sys_clk) disable iff (soft_rst)
		(req_valid && !req.wr && cur_addr == `ACFG_OFS_VENDOR_LO) |=>
		(rsp_valid && rsp_rdata == VENDOR_CODE[7:0]))
		else $error("vendor code low byte wrong");

	a_vendor_high: assert property (
		@(posedge sys_clk) disable iff (soft_rst)
		(req_valid && !req.wr && cur_addr == `ACFG_OFS_VENDOR_HI) |=>
		(rsp_valid && rsp_rdata == VENDOR_CODE[15:8]))
		else $error("vendor code high byte wrong");

	a_rsp_follows: assert property (
		@(posedge sys_clk) disable iff (soft_rst)
		req_valid |=> rsp_valid)
		else $error("byte access got no answer");

	a_rsp_idle: assert property (
		@(posedge sys_clk) disable iff (soft_rst)
		!req_valid |=> !rsp_valid)
		else $error("answer without a request");

	a_addr_hold: assert property (
		@(posedge sys_clk) disable iff (soft_rst)
		(req_valid && user_cfg_q[`ACFG_HOLD_ADDR_BIT]) |=>
		(addr_q == $past(cur_addr)))
		else $error("address moved while held");

	a_addr_ascend: assert property (
		@(posedge sys_clk) disable iff (soft_rst)
		(req_valid && !user_cfg_q[`ACFG_HOLD_ADDR_BIT] &&
		 address_direction_bit && cur_addr != `ACFG_ADDR_MAX) |=>
		(addr_q == $past(cur_addr) + 15'h0001))
		else $error("ascending address did not step");

	a_addr_descend: assert property (
		@(posedge sys_clk) disable iff (soft_rst)
		(req_valid && !user_cfg_q[`ACFG_HOLD_ADDR_BIT] &&
		 !address_direction_bit && cur_addr != 15'h0000) |=>
		(addr_q == $past(cur_addr) - 15'h0001))
		else $error("descending address did not step");

	a_addr_wrap: assert property (
		@(posedge sys_clk) disable iff (soft_rst)
		(req_valid && !user_cfg_q[`ACFG_HOLD_ADDR_BIT] &&
		 !address_direction_bit && cur_addr == 15'h0000) |=>
		(addr_q == `ACFG_ADDR_MAX))
		else $error("descending address did not wrap");

	sequence s_trig_rise;
		wr_en && cur_addr == `ACFG_OFS_DIG_RESET &&
		req.wdata[`ACFG_DIG_RESET_BIT] &&
		!dig_reset_q[`ACFG_DIG_RESET_BIT];
	endsequence
	a_reset_edge: assert property (
		@(posedge sys_clk) disable iff (rst)
		s_trig_rise |=> digital_reset_pulse ##1
		(!digital_reset_pulse && gain_hi_q == `ACFG_RST_GAIN_HI &&
		 dig_reset_q[`ACFG_DIG_RESET_BIT]))
		else $error("trigger edge did not reset");

	a_no_self_clear: assert property (
		@(posedge sys_clk) disable iff (rst)
		(dig_reset_q[`ACFG_DIG_RESET_BIT] && !wr_en) |=>
		dig_reset_q[`ACFG_DIG_RESET_BIT])
		else $error("trigger bit cleared itself");

	a_gain_hi_mask: assert property (
		@(posedge sys_clk) disable iff (soft_rst)
		(wr_en && cur_addr == `ACFG_OFS_GAIN_HI) |=>
		(gain_hi_q == ($past(req.wdata) & `ACFG_HI_FIELD_MASK)))
		else $error("gain high reserved bit stored");

	a_gain_concat: assert property (
		@(posedge sys_clk) disable iff (soft_rst)
		(wr_en && cur_addr == `ACFG_OFS_GAIN_LO) |=>
		(fullscale_gain_code == {gain_hi_q[6:0], $past(req.wdata)}))
		else $error("gain code not high then low");
endmodule

// >>> src/acfg_params.svh
// register offsets, reset values and field positions of the config bank
`ifndef ACFG_PARAMS_SVH
`define ACFG_PARAMS_SVH
`define ACFG_ADDR_W          15
`define ACFG_ADDR_MAX        15'h7fff
`define ACFG_OFS_VENDOR_HI   15'h000c
`define ACFG_OFS_VENDOR_LO   15'h000d
`define ACFG_OFS_USER_CFG    15'h0010
`define ACFG_OFS_DIG_RESET   15'h0021
`define ACFG_OFS_GAIN_HI     15'h0022
`define ACFG_OFS_GAIN_LO     15'h0023
`define ACFG_OFS_OFFSET_HI   15'h0025
`define ACFG_OFS_OFFSET_LO   15'h0026
`define ACFG_RST_USER_CFG    8'h00
`define ACFG_RST_DIG_RESET   8'h00
`define ACFG_RST_GAIN_HI     8'h40
`define ACFG_RST_GAIN_LO     8'h00
`define ACFG_RST_OFFSET_HI   8'h40
`define ACFG_RST_OFFSET_LO   8'h00
`define ACFG_HOLD_ADDR_BIT   0
`define ACFG_DIG_RESET_BIT   0
`define ACFG_HI_FIELD_MASK   8'h7f
`define ACFG_GAIN_MIN        15'h0000
`define ACFG_GAIN_DEFAULT    15'h4000
`define ACFG_GAIN_MAX        15'h7fff
`endif

// >>> src/acfg_pkg.sv
// types shared by the configuration register bank
package acfg_pkg;
	// one byte access from the serial port framer
	typedef struct packed {
		logic        start;
		logic        wr;
		logic [14:0] addr;
		logic [7:0]  wdata;
	} acfg_req_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] rdata;
	} acfg_rsp_t;

	typedef enum logic [1:0] {
		ACFG_IDLE   = 2'b01,
		ACFG_STREAM = 2'b10
	} acfg_state_t;
endpackage

// >>> testbench/acfg_regs_test.sv
// self-checking bench for the configuration register bank
`timescale 1ns/10ps
module acfg_regs_test;
	localparam logic [15:0] VC = 16'h3c96; // arbitrary value
	logic                sys_clk = 1'b0;
	logic                rst = 1'b1;
	acfg_pkg::acfg_req_t req = '0;
	logic                req_valid = 1'b0;
	logic                address_direction_bit = 1'b1;
	logic                rsp_valid;
	logic                digital_reset_pulse;
	logic                hold_address;
	logic [7:0]          rsp_rdata;
	logic [14:0]         fullscale_gain_code;
	logic [14:0]         offset_trim_code;
	logic [31:0]         rnd = 32'h0000_45d8;
	logic [7:0]          m_uc, m_dr, m_gh, m_gl, m_oh, m_ol;
	logic [14:0]         sa;
	bit                  must_start;
	int                  err_count = 0;
	int                  total_checks = 0;
	logic [14:0]         tbl [12] = '{15'h000c, 15'h000d, 15'h0010,
		15'h0021, 15'h0022, 15'h0023, 15'h0025, 15'h0026, 15'h0011,
		15'h0024, 15'h7fff, 15'h0000};
	logic [14:0]         gains [3] = '{15'h0000, 15'h7fff, 15'h4000};

	acfg_regs #(.VENDOR_CODE(VC)) dut (
		.sys_clk(sys_clk), .rst(rst), .req(req), .req_valid(req_valid),
		.address_direction_bit(address_direction_bit),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.fullscale_gain_code(fullscale_gain_code),
		.offset_trim_code(offset_trim_code),
		.digital_reset_pulse(digital_reset_pulse),
		.hold_address(hold_address));

	initial begin
		forever #10 sys_clk = ~sys_clk;
	end

	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic report(logic [15:0] e, logic [15:0] g);
		total_checks++;
		if (e !== g) begin
			err_count++;
			$display("MISMATCH at %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic chk_byte(logic [7:0] e, logic [7:0] g);
		report({8'h00, e}, {8'h00, g});
	endtask
	task automatic chk_code(logic [14:0] e, logic [14:0] g);
		report({1'b0, e}, {1'b0, g});
	endtask
	task automatic chk_flag(logic e, logic g);
		report({15'h0000, e}, {15'h0000, g});
	endtask

	function automatic logic [7:0] m_read(logic [14:0] a);
		case (a)
		15'h000c: return VC[15:8];
		15'h000d: return VC[7:0];
		15'h0010: return m_uc;
		15'h0021: return m_dr;
		15'h0022: return m_gh;
		15'h0023: return m_gl;
		15'h0025: return m_oh;
		15'h0026: return m_ol;
		default: return 8'h00;
		endcase
	endfunction

	// trigger register survives its own soft reset
	task automatic m_soft();
		m_uc = 8'h00;
		m_gh = 8'h40;
		m_gl = 8'h00;
		m_oh = 8'h40;
		m_ol = 8'h00;
		must_start = 1'b1;
	endtask

	task automatic access(logic st, logic wr, logic [14:0] a, logic [7:0] d,
			logic dir);
		logic [14:0] ea;
		logic        rise;
		@(posedge sys_clk);
		req <= '{start: st, wr: wr, addr: a, wdata: d};
		req_valid <= 1'b1;
		address_direction_bit <= dir;
		#1;
		chk_code({m_gh[6:0], m_gl}, fullscale_gain_code);
		chk_code({m_oh[6:0], m_ol}, offset_trim_code);
		chk_flag(m_uc[0], hold_address);
		chk_flag(1'b0, rsp_valid);
		ea = (st | must_start) ? a : sa;
		// only a reset returns the bank to its idle start-address state
		must_start = 1'b0;
		rise = wr && ea == 15'h0021 && !m_dr[0] && d[0];
		@(posedge sys_clk);
		req_valid <= 1'b0;
		#1;
		chk_flag(1'b1, rsp_valid);
		chk_byte(m_read(ea), rsp_rdata);
		chk_flag(rise, digital_reset_pulse);
		sa = m_uc[0] ? ea : (dir ? ea + 15'h0001 : ea - 15'h0001);
		if (wr) begin
			case (ea)
			15'h0010: m_uc = d;
			15'h0021: m_dr = d;
			15'h0022: m_gh = {1'b0, d[6:0]};
			15'h0023: m_gl = d;
			15'h0025: m_oh = {1'b0, d[6:0]};
			15'h0026: m_ol = d;
			default: ;
			endcase
		end
		if (rise) begin
			m_soft();
			repeat (2) @(posedge sys_clk);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge sys_clk);
		err_count++;
		print_verdict();
	end

	initial begin
		m_soft();
		m_dr = 8'h00;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		foreach (tbl[i]) access(1'b1, 1'b0, tbl[i], 8'h00, 1'b1);
		access(1'b1, 1'b1, 15'h000c, 8'hff, 1'b1);
		access(1'b0, 1'b0, 15'h0000, 8'h00, 1'b1);
		foreach (gains[i]) begin
			access(1'b1, 1'b1, 15'h0022, {1'b1, gains[i][14:8]}, 1'b1);
			access(1'b0, 1'b1, 15'h0000, gains[i][7:0], 1'b1);
		end
		access(1'b1, 1'b1, 15'h0026, 8'h3c, 1'b0);
		access(1'b0, 1'b1, 15'h0000, 8'h7e, 1'b0);
		access(1'b1, 1'b0, 15'h0000, 8'h00, 1'b0);
		access(1'b0, 1'b0, 15'h0000, 8'h00, 1'b0);
		access(1'b1, 1'b1, 15'h0010, 8'h01, 1'b1);
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			access(i == 0, i < 3, 15'h0023, rnd[7:0], 1'b1);
		end
		access(1'b1, 1'b1, 15'h0010, 8'h00, 1'b1);
		access(1'b1, 1'b1, 15'h0021, 8'h00, 1'b1);
		access(1'b1, 1'b1, 15'h0021, 8'h01, 1'b1);
		access(1'b1, 1'b1, 15'h0021, 8'h01, 1'b1);
		for (int i = 0; i < 120; i++) begin
			rnd = lfsr(rnd);
			access(rnd[0], rnd[1], tbl[rnd[7:4] % 12], rnd[15:8], rnd[2]);
		end
		print_verdict();
	end
endmodule
